// File: verilog/dsp_pkg.sv
package dsp_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] DSP_OFS_P2_CTL = 8'h8e;
  localparam logic [7:0] DSP_OFS_P2_BUF = 8'h8f;
  localparam logic [7:0] DSP_OFS_P1_CTL = 8'h98;
  localparam logic [7:0] DSP_OFS_P1_BUF = 8'h99;
  localparam logic [7:0] DSP_OFS_IRQ_STAT = 8'hc0;
  localparam logic [7:0] DSP_OFS_IRQ_CLR = 8'hc1;
  localparam logic [7:0] DSP_OFS_IRQ_EN = 8'hc2;
  localparam logic [7:0] DSP_OFS_P1_DIV = 8'hc3;
  localparam logic [7:0] DSP_OFS_P2_DIV = 8'hc4;
  localparam logic [7:0] DSP_OFS_CFG = 8'hc5;

  // control register field positions (both ports share the low nibble)
  localparam int DSP_F_MODE_HI = 7;
  localparam int DSP_F_MODE_LO = 6;
  localparam int DSP_F_FILT = 5;
  localparam int DSP_F_REN = 4;
  localparam int DSP_F_TB = 3;
  localparam int DSP_F_RB = 2;
  localparam int DSP_F_TI = 1;
  localparam int DSP_F_RI = 0;
  localparam int DSP_F_CFG_DIV32 = 0;

  // interrupt status bit positions
  localparam int DSP_IRQ_TX1 = 0;
  localparam int DSP_IRQ_RX1 = 1;
  localparam int DSP_IRQ_TX2 = 2;
  localparam int DSP_IRQ_RX2 = 3;
  localparam int DSP_IRQ_W = 4;

  // reset values
  localparam logic [7:0] DSP_CTL_RST = 8'h00;
  localparam logic [7:0] DSP_DIV_RST = 8'h0f;
  localparam logic [7:0] DSP_CFG_RST = 8'h00;
  localparam logic [3:0] DSP_IRQ_RST = 4'h0;

  // timing: 16 samples per framed bit, fixed rate is sysclk / 32 or / 64
  localparam int DSP_OVS = 16;
  localparam int DSP_FIX_DIV32 = 32;
  localparam int DSP_FIX_DIV64 = 64;
  localparam logic [7:0] DSP_RLD32 = 8'(DSP_FIX_DIV32 / DSP_OVS - 1);
  localparam logic [7:0] DSP_RLD64 = 8'(DSP_FIX_DIV64 / DSP_OVS - 1);
  localparam logic [3:0] DSP_SUB_LAST = 4'(DSP_OVS - 1);
  localparam logic [3:0] DSP_SUB_MID = 4'(DSP_OVS / 2 - 1);
  localparam logic [3:0] DSP_SH_LAST = 4'h1;

  // frame lengths in bit times
  localparam logic [3:0] DSP_LEN_SHIFT = 4'h8;
  localparam logic [3:0] DSP_LEN_8 = 4'ha;
  localparam logic [3:0] DSP_LEN_9 = 4'hb;

  typedef enum logic [1:0] {
    DSP_MODE_SHIFT = 2'b00,
    DSP_MODE_8V = 2'b01,
    DSP_MODE_9F = 2'b10,
    DSP_MODE_9V = 2'b11
  } dsp_mode_e;

  typedef enum logic [1:0] {
    DSP_RX_IDLE = 2'b00,
    DSP_RX_RUN = 2'b01
  } dsp_rxst_e;

  // per-port settings handed to an engine
  typedef struct packed {
    dsp_mode_e mode;
    logic filt;
    logic rx_allow;
    logic tx_ninth;
    logic rx_arm;
    logic [7:0] div;
  } dsp_cfg_s;

  // received word with its ninth bit
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } dsp_rxw_s;
endpackage

// File: verilog/dsp_top.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Behaviour
// RQ1: mode 00 is shift register at half clock
// RQ2: mode 01 is 8-bit frames, programmable rate
// RQ3: mode 10 is 9-bit, clock over 32/64
// RQ4: mode 11 is 9-bit frames, programmable rate
// RQ5: address filter bit gates receive completion
// RQ6: 9-bit filtered: ninth bit 0 gives no flag
// RQ7: 8-bit filtered: flag only with valid stop
// RQ8: software keeps filter clear in shift mode
// RQ9: buffer address splits transmit and receive storage
// RQ10: second port bit picks 8 or 9-bit
// RQ11: reception enable bit blocks or allows receive
// RQ12: transmit flag set at stop start, software clears
// RQ13: receive flag set at stop sample, software clears
// RQ14: ninth bit sent and received bit captured
// RQ15: buffer write starts a frame

// one serial engine: transmitter, receiver and its own rate divider
module dsp_sio (
  input wire logic mclk,
  input wire logic rst_b,
  input dsp_pkg::dsp_cfg_s cfg,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  input wire logic rx_i,
  output logic tx_done,
  output logic rx_done,
  output dsp_pkg::dsp_rxw_s rxw,
  output logic ser_o,
  output logic dat_o,
  output logic dat_oe
);
  // mode decode
  wire logic m_shift = (cfg.mode == dsp_pkg::DSP_MODE_SHIFT);
  wire logic m_nine = cfg.mode[1];
  wire logic [3:0] f_len = m_shift ? dsp_pkg::DSP_LEN_SHIFT :
                           (m_nine ? dsp_pkg::DSP_LEN_9 : dsp_pkg::DSP_LEN_8);

  // rate divider: one oversample tick every div+1 clocks
  logic [7:0] div_q;
  wire logic tick = (div_q == 8'h00);
  // count down and reload from the selected divisor
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) div_q <= 8'h00;
    else div_q <= tick ? cfg.div : div_q - 8'h01;
  end

  // shift mode steps every clock so a bit lasts two clocks
  wire logic step = m_shift | tick; // [RQ1]
  wire logic [3:0] sub_end = m_shift ? dsp_pkg::DSP_SH_LAST : dsp_pkg::DSP_SUB_LAST;
  wire logic [3:0] sub_smp = m_shift ? dsp_pkg::DSP_SH_LAST : dsp_pkg::DSP_SUB_MID;

  // ---------------- transmitter ----------------
  logic tx_busy_q;
  logic [10:0] tx_sh_q; // idles all ones so the line rests high
  logic [3:0] tx_left_q; // bit times still to send
  logic [3:0] tx_sub_q;
  wire logic tx_bend = tx_busy_q & step & (tx_sub_q == sub_end);
  // frame image, least significant bit leaves first
  wire logic [10:0] tx_img = m_shift ? {3'b111, tx_data} :
                             m_nine ? {1'b1, cfg.tx_ninth, tx_data, 1'b0} : // [RQ14]
                             {2'b11, tx_data, 1'b0};
  // a start while busy is dropped; the frame in flight is kept whole
  wire logic tx_go = tx_start & ~tx_busy_q; // [RQ15]

  // transmit shifter and bit counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 11'h7ff;
      tx_left_q <= 4'h0;
      tx_sub_q <= 4'h0;
    end else if (tx_go) begin
      tx_busy_q <= 1'b1;
      tx_sh_q <= tx_img;
      tx_left_q <= f_len;
      tx_sub_q <= 4'h0;
    end else if (tx_bend) begin
      tx_sh_q <= {1'b1, tx_sh_q[10:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_sub_q <= 4'h0;
      if (tx_left_q == 4'h1) tx_busy_q <= 1'b0;
    end else if (tx_busy_q & step) begin
      tx_sub_q <= tx_sub_q + 4'h1;
    end
  end

  // framed: flag as the stop bit begins; shift: after the last bit
  assign tx_done = tx_bend & (m_shift ? (tx_left_q == 4'h1) : (tx_left_q == 4'h2)); // [RQ12]

  // ---------------- receiver ----------------
  dsp_pkg::dsp_rxst_e rx_st_q;
  logic [8:0] rx_sh_q; // bits enter at the top
  logic [3:0] rx_idx_q; // index of the bit being timed
  logic [3:0] rx_sub_q;
  logic rx_prev_q; // line level one clock ago
  dsp_pkg::dsp_rxw_s rxw_q;

  wire logic rx_run = (rx_st_q == dsp_pkg::DSP_RX_RUN);
  wire logic rx_fall = rx_prev_q & ~rx_i;
  // framed start needs enable and a falling edge; shift start needs arm
  wire logic rx_go_f = ~rx_run & ~m_shift & cfg.rx_allow & rx_fall; // [RQ11]
  // shift reception waits for the transmitter since they share the clock pin
  wire logic rx_go_s = ~rx_run & m_shift & cfg.rx_arm & ~tx_busy_q & ~tx_start; // [RQ11]
  wire logic rx_smp = rx_run & step & (rx_sub_q == sub_smp);
  wire logic rx_bend = rx_run & step & (rx_sub_q == sub_end);
  wire logic rx_last = (rx_idx_q == f_len - 4'h1);
  wire logic rx_badst = rx_smp & ~m_shift & (rx_idx_q == 4'h0) & rx_i;
  wire logic rx_shin = rx_smp & (m_shift | ((rx_idx_q != 4'h0) & ~rx_last));
  wire logic rx_fin = rx_smp & rx_last;

  // filtering: 9-bit needs ninth bit 1, 8-bit needs a good stop bit
  wire logic ok_nine = ~cfg.filt | rx_sh_q[8]; // [RQ5] [RQ6]
  wire logic ok_eight = ~cfg.filt | rx_i; // [RQ7]
  // shift mode ignores the filter bit; software keeps it clear there
  wire logic rx_ok = m_shift | (m_nine ? ok_nine : ok_eight); // [RQ8]
  // shifting in at the top leaves eight-bit data one place high
  wire logic [7:0] rx_word = m_nine ? rx_sh_q[7:0] :
                             (m_shift ? {rx_i, rx_sh_q[8:2]} : rx_sh_q[8:1]);
  // ninth bit in 9-bit modes, stop bit in the 8-bit mode
  wire logic rx_nin = m_nine ? rx_sh_q[8] : rx_i; // [RQ14]

  // receive sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q <= dsp_pkg::DSP_RX_IDLE;
      rx_sh_q <= 9'h000;
      rx_idx_q <= 4'h0;
      rx_sub_q <= 4'h0;
    end else if (rx_go_f | rx_go_s) begin
      rx_st_q <= dsp_pkg::DSP_RX_RUN;
      rx_idx_q <= 4'h0;
      rx_sub_q <= 4'h0;
    end else if (rx_badst | rx_fin) begin
      // false start or frame complete: back to hunting
      rx_st_q <= dsp_pkg::DSP_RX_IDLE;
    end else if (rx_run & step) begin
      if (rx_shin) rx_sh_q <= {rx_i, rx_sh_q[8:1]};
      if (rx_bend) begin
        rx_idx_q <= rx_idx_q + 4'h1;
        rx_sub_q <= 4'h0;
      end else begin
        rx_sub_q <= rx_sub_q + 4'h1;
      end
    end
  end

  // line history for start edge detection
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rx_prev_q <= 1'b1;
    else rx_prev_q <= rx_i;
  end

  // received word only replaced by an accepted frame
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rxw_q <= '0;
    else if (rx_fin & rx_ok) rxw_q <= '{data: rx_word, ninth: rx_nin};
  end

  assign rx_done = rx_fin & rx_ok; // [RQ13]
  assign rxw = rxw_q;

  // ---------------- pins ----------------
  // shift mode: clock low in first half of each bit, data sampled on rise
  logic sclk_q;
  wire logic sh_busy = tx_busy_q | (rx_run & m_shift);
  wire logic [3:0] sh_sub = tx_busy_q ? tx_sub_q : rx_sub_q;
  wire logic sclk_d = ~sh_busy | (sh_sub == dsp_pkg::DSP_SH_LAST);
  logic dat_q; // shift data, delayed to line up with the clock
  logic oe_q; // drive enable, delayed with the data
  // registered so the shift clock has no decode glitches; data and enable
  // take the same delay, so data moves as the clock falls, never as it rises
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b1;
      dat_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      sclk_q <= sclk_d;
      dat_q <= tx_sh_q[0];
      oe_q <= m_shift & tx_busy_q;
    end
  end

  assign ser_o = m_shift ? sclk_q : tx_sh_q[0]; // [RQ1] [RQ2]
  assign dat_o = dat_q; // [RQ1]
  assign dat_oe = oe_q;
endmodule

// register file, flags and interrupt for both serial ports
module dsp_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic p1_rxd_i,
  output logic p1_rxd_o,
  output logic p1_rxd_oe,
  output logic p1_txd,
  input wire logic p2_rxd_i,
  output logic p2_txd
);
  // address decode
  wire logic wr_p1c = reg_wr & (reg_addr == dsp_pkg::DSP_OFS_P1_CTL);
  wire logic wr_p1b = reg_wr & (reg_addr == dsp_pkg::DSP_OFS_P1_BUF);
  wire logic wr_p2c = reg_wr & (reg_addr == dsp_pkg::DSP_OFS_P2_CTL);
  wire logic wr_p2b = reg_wr & (reg_addr == dsp_pkg::DSP_OFS_P2_BUF);
  wire logic wr_clr = reg_wr & (reg_addr == dsp_pkg::DSP_OFS_IRQ_CLR);
  wire logic wr_ien = reg_wr & (reg_addr == dsp_pkg::DSP_OFS_IRQ_EN);
  wire logic wr_d1 = reg_wr & (reg_addr == dsp_pkg::DSP_OFS_P1_DIV);
  wire logic wr_d2 = reg_wr & (reg_addr == dsp_pkg::DSP_OFS_P2_DIV);
  wire logic wr_cfg = reg_wr & (reg_addr == dsp_pkg::DSP_OFS_CFG);

  // software state
  logic [7:0] p1c_q; // port1_control
  logic [7:0] p2c_q; // port2_control, bits 6:5 unused
  logic [7:0] d1_q; // port 1 bit-rate divisor
  logic [7:0] d2_q; // port 2 bit-rate divisor
  logic [7:0] cfg_q; // bit 0 picks the /32 fixed rate
  logic [3:0] ist_q; // sticky interrupt status
  logic [3:0] ien_q; // interrupt enable
  logic [7:0] rdata_q;

  // engine hooks
  logic tx1_done, rx1_done, tx2_done, rx2_done;
  dsp_pkg::dsp_rxw_s rxw1, rxw2;
  dsp_pkg::dsp_cfg_s cfg1, cfg2;

  // fixed-rate mode bypasses the programmable divisor
  wire logic p1_fix = (p1c_q[7:6] == dsp_pkg::DSP_MODE_9F);
  wire logic [7:0] d1_eff = p1_fix ? (cfg_q[dsp_pkg::DSP_F_CFG_DIV32] ?
                            dsp_pkg::DSP_RLD32 : dsp_pkg::DSP_RLD64) : d1_q; // [RQ3]

  // port 1 settings: all four modes
  assign cfg1 = '{mode: dsp_pkg::dsp_mode_e'(p1c_q[7:6]), // [RQ1] [RQ2] [RQ3] [RQ4]
                  filt: p1c_q[dsp_pkg::DSP_F_FILT],
                  rx_allow: p1c_q[dsp_pkg::DSP_F_REN],
                  tx_ninth: p1c_q[dsp_pkg::DSP_F_TB],
                  rx_arm: p1c_q[dsp_pkg::DSP_F_REN] & ~p1c_q[dsp_pkg::DSP_F_RI],
                  div: d1_eff};
  // port 2 settings: only the two programmable-rate modes exist
  assign cfg2 = '{mode: p2c_q[7] ? dsp_pkg::DSP_MODE_9V : dsp_pkg::DSP_MODE_8V, // [RQ10]
                  filt: 1'b0,
                  rx_allow: p2c_q[dsp_pkg::DSP_F_REN],
                  tx_ninth: p2c_q[dsp_pkg::DSP_F_TB],
                  rx_arm: 1'b0,
                  div: d2_q};

  // two identical engines; writes feed transmit, reads see receive
  dsp_sio u_p1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .cfg(cfg1),
    .tx_start(wr_p1b), // [RQ9] [RQ15]
    .tx_data(reg_wdata),
    .rx_i(p1_rxd_i),
    .tx_done(tx1_done),
    .rx_done(rx1_done),
    .rxw(rxw1),
    .ser_o(p1_txd),
    .dat_o(p1_rxd_o),
    .dat_oe(p1_rxd_oe)
  );

  dsp_sio u_p2 (
    .mclk(mclk),
    .rst_b(rst_b),
    .cfg(cfg2),
    .tx_start(wr_p2b), // [RQ9] [RQ15]
    .tx_data(reg_wdata),
    .rx_i(p2_rxd_i),
    .tx_done(tx2_done),
    .rx_done(rx2_done),
    .rxw(rxw2),
    .ser_o(p2_txd),
    .dat_o(),
    .dat_oe()
  );

  // engines latch the word with the flag, so the ninth bit follows a clock later
  logic rx1_lat_q; // port 1 accepted a frame last clock
  logic rx2_lat_q; // port 2 accepted a frame last clock
  // control registers; hardware set beats a software write in the same cycle
  wire logic [7:0] p1c_w = wr_p1c ? reg_wdata : p1c_q;
  wire logic [7:0] p2c_w = wr_p2c ? {reg_wdata[7], 2'b00, reg_wdata[4:0]} : p2c_q;
  wire logic [7:0] p1c_d = {p1c_w[7:3],
                            rx1_lat_q ? rxw1.ninth : p1c_w[2], // [RQ14]
                            p1c_w[1] | tx1_done, // [RQ12]
                            p1c_w[0] | rx1_done}; // [RQ13]
  wire logic [7:0] p2c_d = {p2c_w[7:3],
                            rx2_lat_q ? rxw2.ninth : p2c_w[2], // [RQ14]
                            p2c_w[1] | tx2_done, // [RQ12]
                            p2c_w[0] | rx2_done}; // [RQ13]

  // control register storage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      p1c_q <= dsp_pkg::DSP_CTL_RST;
      p2c_q <= dsp_pkg::DSP_CTL_RST;
      rx1_lat_q <= 1'b0;
      rx2_lat_q <= 1'b0;
    end else begin
      p1c_q <= p1c_d;
      p2c_q <= p2c_d;
      rx1_lat_q <= rx1_done;
      rx2_lat_q <= rx2_done;
    end
  end

  // divisors and option register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      d1_q <= dsp_pkg::DSP_DIV_RST;
      d2_q <= dsp_pkg::DSP_DIV_RST;
      cfg_q <= dsp_pkg::DSP_CFG_RST;
    end else begin
      if (wr_d1) d1_q <= reg_wdata;
      if (wr_d2) d2_q <= reg_wdata;
      if (wr_cfg) cfg_q <= reg_wdata;
    end
  end

  // interrupt events; set wins over a clear in the same cycle
  wire logic [3:0] ev = {rx2_done, tx2_done, rx1_done, tx1_done};
  wire logic [3:0] ist_d = (ist_q & ~(wr_clr ? reg_wdata[3:0] : 4'h0)) | ev;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ist_q <= dsp_pkg::DSP_IRQ_RST;
      ien_q <= dsp_pkg::DSP_IRQ_RST;
    end else begin
      ist_q <= ist_d;
      if (wr_ien) ien_q <= reg_wdata[3:0];
    end
  end
  assign irq = |(ist_q & ien_q);

  // read mux; unmapped and write-only addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      dsp_pkg::DSP_OFS_P1_CTL: rd_mux = p1c_q;
      dsp_pkg::DSP_OFS_P1_BUF: rd_mux = rxw1.data; // [RQ9]
      dsp_pkg::DSP_OFS_P2_CTL: rd_mux = p2c_q;
      dsp_pkg::DSP_OFS_P2_BUF: rd_mux = rxw2.data; // [RQ9]
      dsp_pkg::DSP_OFS_IRQ_STAT: rd_mux = {4'h0, ist_q};
      dsp_pkg::DSP_OFS_IRQ_EN: rd_mux = {4'h0, ien_q};
      dsp_pkg::DSP_OFS_P1_DIV: rd_mux = d1_q;
      dsp_pkg::DSP_OFS_P2_DIV: rd_mux = d2_q;
      dsp_pkg::DSP_OFS_CFG: rd_mux = cfg_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rdata_q <= 8'h00;
    else rdata_q <= reg_rd ? rd_mux : 8'h00;
  end
  assign reg_rdata = rdata_q;
endmodule

// File: tb/dsp_sva.sv
`timescale 1ns/1ps
// port-level checker for the dual serial block
module dsp_sva (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic p1_rxd_i,
  input wire logic p1_rxd_o,
  input wire logic p1_rxd_oe,
  input wire logic p1_txd,
  input wire logic p2_rxd_i,
  input wire logic p2_txd
);
  logic [1:0] mode_q; // port1 mode as last written
  logic [7:0] hi1_q; // high run on port1 line
  logic [7:0] hi2_q; // high run on port2 line
  logic wr_p1c; // write to port1 control
  assign wr_p1c = reg_wr && reg_addr == dsp_pkg::DSP_OFS_P1_CTL;
  // saturating runs, so only a quiet line arms the start checks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 2'b00;
      hi1_q <= 8'h00;
      hi2_q <= 8'h00;
    end else begin
      mode_q <= wr_p1c ? reg_wdata[7:6] : mode_q;
      hi1_q <= !p1_txd ? 8'h00 : hi1_q + 8'(hi1_q != 8'hff);
      hi2_q <= !p2_txd ? 8'h00 : hi2_q + 8'(hi2_q != 8'hff);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_clr_rd;
    $past(reg_rd) && $past(reg_addr) == dsp_pkg::DSP_OFS_IRQ_CLR |-> reg_rdata == 8'h00;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear register read back");
  property p_sh_low; $fell(p1_txd) && p1_rxd_oe |=> p1_txd; endproperty
  a_sh_low: assert property (p_sh_low) else $error("shift clock low too long");
  property p_sh_high; $rose(p1_txd) && p1_rxd_oe ##1 p1_rxd_oe |-> !p1_txd; endproperty
  a_sh_high: assert property (p_sh_high) else $error("shift clock high too long");
  property p_sh_data; $rose(p1_txd) && p1_rxd_oe |-> $stable(p1_rxd_o); endproperty
  a_sh_data: assert property (p_sh_data) else $error("shift data moved on high");
  property p_oe_len; $rose(p1_rxd_oe) |-> p1_rxd_oe[*8] ##[6:12] !p1_rxd_oe; endproperty
  a_oe_len: assert property (p_oe_len) else $error("shift burst length wrong");
  property p_oe_mode; p1_rxd_oe |-> mode_q == 2'b00; endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("data pin driven in framed mode");
  property p_p1_go;
    reg_wr && reg_addr == dsp_pkg::DSP_OFS_P1_BUF && mode_q != 2'b00 && hi1_q > 8'h40
      |-> ##[1:300] !p1_txd;
  endproperty
  a_p1_go: assert property (p_p1_go) else $error("port1 frame did not start");
  property p_p2_go;
    reg_wr && reg_addr == dsp_pkg::DSP_OFS_P2_BUF && hi2_q > 8'h40 |-> ##[1:300] !p2_txd;
  endproperty
  a_p2_go: assert property (p_p2_go) else $error("port2 frame did not start");
  property p_irq_fall; $fell(irq) |-> $past(reg_wr); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
  c_shift: cover property ($rose(p1_rxd_oe));
  c_irq: cover property ($rose(irq));
  c_p2: cover property ($fell(p2_txd));
endmodule

bind dsp_top dsp_sva i_dsp_sva (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .p1_rxd_i(p1_rxd_i), .p1_rxd_o(p1_rxd_o), .p1_rxd_oe(p1_rxd_oe),
  .p1_txd(p1_txd), .p2_rxd_i(p2_rxd_i), .p2_txd(p2_txd));

// File: tb/dsp_far_end.sv
`timescale 1ns/1ps
// remote serial node on both links: frame sender and decoder
module dsp_far_end (
  input wire logic mclk,
  input wire logic [1:0] ser_in,
  output logic [1:0] ser_out
);
  int bit_clks [2] = '{16, 16}; // clocks per bit, per link
  logic nine [2] = '{1'b0, 1'b0}; // frame carries a ninth bit
  logic [7:0] got_data [2]; // last decoded byte
  logic got_ninth [2]; // last ninth bit, or stop level
  initial ser_out = 2'b11; // idle mark level
  // start, data lsb first, optional ninth, stop
  task automatic send(input int p, input logic [7:0] d, input logic n9, input logic stp);
    logic [10:0] f;
    f = nine[p] ? {stp, n9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < 10 + int'(nine[p]); i++) begin
      ser_out[p] <= f[i];
      repeat (bit_clks[p]) @(posedge mclk);
    end
    ser_out[p] <= 1'b1;
  endtask
  // mid-bit sampling; a bad stop is simply recorded in 8-bit frames, 9-bit stops are not sampled
  for (genvar g = 0; g < 2; g++) begin : g_rx
    always begin
      @(negedge ser_in[g]);
      repeat (bit_clks[g] / 2) @(posedge mclk);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_clks[g]) @(posedge mclk);
        if (i < 8) got_data[g][i] = ser_in[g];
        else got_ninth[g] = ser_in[g];
      end
    end
  end
endmodule

// File: tb/dsp_tb_top.sv
`timescale 1ns/1ps
// bench: register tasks plus a remote node on both links
module dsp_tb_top;
  logic mclk; // system clock
  logic rst_b; // active-low reset
  logic [7:0] reg_addr; // register address
  logic [7:0] reg_wdata; // write data
  logic reg_wr; // write strobe
  logic reg_rd; // read strobe
  logic [7:0] reg_rdata; // read data
  logic irq; // level interrupt
  logic p1_rxd_o; // shift data out
  logic p1_rxd_oe; // shift data drive
  logic [1:0] dev_tx; // device lines to far end
  logic [1:0] far_tx; // far-end lines to device
  logic p1_rx_wire; // shared port1 data pin
  logic [7:0] sh; // shift capture
  int fail_count = 0; // mismatches
  int num_checks = 0; // comparisons
  int cyc = 0; // cycle count for the timeout
  assign p1_rx_wire = p1_rxd_oe ? p1_rxd_o : far_tx[0];
  dsp_top i_dsp_top (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .p1_rxd_i(p1_rx_wire), .p1_rxd_o(p1_rxd_o), .p1_rxd_oe(p1_rxd_oe),
    .p1_txd(dev_tx[0]), .p2_rxd_i(far_tx[1]), .p2_txd(dev_tx[1]));
  dsp_far_end i_dsp_far_end (.mclk(mclk), .ser_in(dev_tx), .ser_out(far_tx));
  // 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // verdict in one place
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // gap cycle after each strobe so a strobe is never assigned twice at one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // data stands the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  // poll a control flag with a bounded count
  task automatic wait_bit(input logic [7:0] a, input int b);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 600 && v[b] !== 1'b1; i++) rd(a, v);
    chk("flag", 8'h01, {7'h0, v[b]});
  endtask
  // receive one frame from the far end, then send one back
  task automatic xfer(input int p, input logic [7:0] c, input logic nine, input int bc,
      input logic [7:0] d, input logic n9, input logic stp, input logic ok);
    logic [7:0] ca;
    logic [7:0] ba;
    logic [7:0] v;
    ca = p ? dsp_pkg::DSP_OFS_P2_CTL : dsp_pkg::DSP_OFS_P1_CTL;
    ba = p ? dsp_pkg::DSP_OFS_P2_BUF : dsp_pkg::DSP_OFS_P1_BUF;
    i_dsp_far_end.nine[p] = nine;
    i_dsp_far_end.bit_clks[p] = bc;
    wr(ca, c);
    i_dsp_far_end.send(p, d, n9, stp);
    rd(ca, v);
    chk("rx_flag", {7'h0, ok}, {7'h0, v[0]});
    if (ok) chk("rx_ninth", {7'h0, nine ? n9 : stp}, {7'h0, v[2]});
    wr(ca, c | (n9 ? 8'h08 : 8'h00));
    wr(ba, ~d);
    wait_bit(ca, 1);
    repeat (3 * bc) @(posedge mclk);
    chk("tx_data", ~d, i_dsp_far_end.got_data[p]);
    if (nine) chk("tx_ninth", {7'h0, n9}, {7'h0, i_dsp_far_end.got_ninth[p]});
    if (ok) rchk(ba, d);
  endtask
  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rchk(dsp_pkg::DSP_OFS_P1_CTL, dsp_pkg::DSP_CTL_RST);
    rchk(dsp_pkg::DSP_OFS_P2_CTL, dsp_pkg::DSP_CTL_RST);
    rchk(dsp_pkg::DSP_OFS_P1_DIV, dsp_pkg::DSP_DIV_RST);
    rchk(dsp_pkg::DSP_OFS_IRQ_STAT, 8'h00);
    rchk(8'h00, 8'h00);
    rchk(dsp_pkg::DSP_OFS_IRQ_CLR, 8'h00);
    $display("test reset done");
    wr(dsp_pkg::DSP_OFS_P1_DIV, 8'h00);
    wr(dsp_pkg::DSP_OFS_P2_DIV, 8'h00);
    xfer(0, 8'h50, 1'b0, 16, 8'h5a, 1'b0, 1'b1, 1'b1);
    xfer(0, 8'h90, 1'b1, 64, 8'h3c, 1'b1, 1'b1, 1'b1);
    xfer(0, 8'hd0, 1'b1, 16, 8'hc3, 1'b1, 1'b1, 1'b1);
    xfer(0, 8'hb0, 1'b1, 64, 8'h96, 1'b0, 1'b1, 1'b0);
    xfer(0, 8'hf0, 1'b1, 16, 8'h69, 1'b1, 1'b1, 1'b1);
    xfer(0, 8'h70, 1'b0, 16, 8'h81, 1'b0, 1'b0, 1'b0);
    wr(dsp_pkg::DSP_OFS_IRQ_CLR, 8'h0f);
    xfer(0, 8'h70, 1'b0, 16, 8'h7e, 1'b0, 1'b1, 1'b1);
    wr(dsp_pkg::DSP_OFS_IRQ_EN, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    rchk(dsp_pkg::DSP_OFS_IRQ_STAT, 8'h03);
    wr(dsp_pkg::DSP_OFS_IRQ_EN, 8'h02);
    chk("irq", 8'h01, {7'h0, irq});
    wr(dsp_pkg::DSP_OFS_IRQ_CLR, 8'h02);
    chk("irq", 8'h00, {7'h0, irq});
    rchk(dsp_pkg::DSP_OFS_IRQ_STAT, 8'h01);
    wr(dsp_pkg::DSP_OFS_IRQ_EN, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    wr(dsp_pkg::DSP_OFS_IRQ_CLR, 8'h0f);
    chk("irq", 8'h00, {7'h0, irq});
    $display("test irq done");
    xfer(0, 8'hc0, 1'b1, 16, 8'h24, 1'b1, 1'b1, 1'b0);
    wr(dsp_pkg::DSP_OFS_CFG, 8'h01);
    xfer(0, 8'h90, 1'b1, 32, 8'ha5, 1'b0, 1'b1, 1'b1);
    xfer(1, 8'h10, 1'b0, 16, 8'h1e, 1'b0, 1'b1, 1'b1);
    xfer(1, 8'h90, 1'b1, 16, 8'he1, 1'b1, 1'b1, 1'b1);
    wr(dsp_pkg::DSP_OFS_P2_DIV, 8'h01); // two clocks per sample
    xfer(1, 8'h10, 1'b0, 32, 8'h4b, 1'b0, 1'b1, 1'b1);
    $display("test framed done");
    wr(dsp_pkg::DSP_OFS_P1_CTL, 8'h00); // filter kept clear
    wr(dsp_pkg::DSP_OFS_P1_BUF, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      @(posedge dev_tx[0]);
      sh[i] = p1_rxd_o;
    end
    chk("shift_data", 8'ha5, sh);
    wait_bit(dsp_pkg::DSP_OFS_P1_CTL, 1);
    // shift reception of the idle line: eight ones, then the flag stops it
    wr(dsp_pkg::DSP_OFS_P1_CTL, 8'h10);
    wait_bit(dsp_pkg::DSP_OFS_P1_CTL, 0);
    rchk(dsp_pkg::DSP_OFS_P1_BUF, 8'hff);
    $display("test shift done");
    end_sim();
  end
endmodule
